// [fcc_pkg.sv]
// Notes on behaviour
// - Function code picks set state, return state, or return option flags.
// - Option bit 0 makes a set persistent; hard reset reverts to persistent values.
// - Return-state success puts state low byte in sector count, high in number.
// - Return-flags success puts flags low byte in sector count, high in number.
// - Other functions leave sector count/number reserved; cylinder and head always reserved.
// - Write cache states: 0001h set-features decides, 0002h forced on, 0003h forced off.
// - While forced, set-features cache changes complete normally but change nothing.
// - Write cache feature starts in state 0001h.
// - Reordering feature: 0001h enable, 0002h disable, enable by default.
// - Setting reordering disable completes without error but is not applied.
// - Logging interval feature takes 0001h to FFFFh minutes; 0000h is invalid.
// - Setting interval resets history: index zero, entry zero current temperature, rest 80h.
// - Queue reset keeps sample period and all temperature limit values.
// - Logging interval is 0001h minute until the host sets another.
package fcc_pkg;
	// Command codes
	localparam logic [15:0] ACT_FEATURE = 16'h0004;
	localparam logic [15:0] FUNC_SET = 16'h0001;
	localparam logic [15:0] FUNC_GET = 16'h0002;
	localparam logic [15:0] FUNC_OPT = 16'h0003;
	localparam logic [15:0] FEAT_WC = 16'h0001;
	localparam logic [15:0] FEAT_RO = 16'h0002;
	localparam logic [15:0] FEAT_LOG = 16'h0003;
	// Feature states and defaults
	localparam logic [15:0] WC_AUTO = 16'h0001;
	localparam logic [15:0] WC_ON = 16'h0002;
	localparam logic [15:0] WC_OFF = 16'h0003;
	localparam logic [15:0] RO_EN = 16'h0001;
	localparam logic [15:0] RO_DIS = 16'h0002;
	localparam logic [15:0] LOG_DEF = 16'h0001;
	localparam logic [15:0] LOG_BAD = 16'h0000;
	localparam logic [7:0] HIST_FILL = 8'h80;
	localparam int OPT_NV_BIT = 0;
	// Completion codes
	localparam logic [7:0] ST_OK = 8'h50;
	localparam logic [7:0] ST_ERR = 8'h51;
	localparam logic [7:0] ER_OK = 8'h00;
	localparam logic [7:0] ER_ABRT = 8'h04;
	// Register byte addresses
	localparam logic [7:0] A_FUNC = 8'h00;
	localparam logic [7:0] A_FEAT = 8'h04;
	localparam logic [7:0] A_STATE = 8'h08;
	localparam logic [7:0] A_OPT = 8'h0C;
	localparam logic [7:0] A_GO = 8'h10;
	localparam logic [7:0] A_RES = 8'h14;
	localparam logic [7:0] A_TF = 8'h18;
	localparam logic [7:0] A_WC = 8'h1C;
	localparam logic [7:0] A_RO = 8'h20;
	localparam logic [7:0] A_LOG = 8'h24;
	localparam logic [7:0] A_INFO = 8'h28;
	localparam logic [7:0] A_HSEL = 8'h2C;
	localparam logic [7:0] A_HDATA = 8'h30;
	localparam logic SETF_DEF = 1'b1;
	// Command sequencer states
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_EXEC = 3'b010,
		S_WAIT = 3'b100
	} fcc_state_e;
endpackage

// [fcc_if.sv]
`timescale 1ns/1ps
`default_nettype none
// History queue link
interface fcc_q_if #(parameter int IW = 7);
	logic clear;
	logic sample;
	logic [7:0] temp;
	logic busy;
	logic [IW-1:0] idx;
	logic [IW-1:0] rd_idx;
	logic [7:0] rd_data;
	modport ctl(output clear, sample, temp, rd_idx, input busy, idx, rd_data);
	modport hist(input clear, sample, temp, rd_idx, output busy, idx, rd_data);
endinterface

// Write cache policy link
interface fcc_wc_if;
	logic [15:0] mode;
	logic setf_req;
	logic setf_en;
	logic setf_done;
	logic wc_on;
	modport ctl(output mode, setf_req, setf_en, input setf_done, wc_on);
	modport cache(input mode, setf_req, setf_en, output setf_done, wc_on);
endinterface
`default_nettype wire

// [fcc_hist.sv]
`timescale 1ns/1ps
`default_nettype none
module fcc_hist
	import fcc_pkg::*;
#(
	parameter int DEPTH = 128
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Controller side
	fcc_q_if.hist q
);
	localparam int IW = $clog2(DEPTH);
	localparam logic [IW-1:0] LAST = IW'(DEPTH - 1);
	logic [7:0] mem [DEPTH];
	logic [IW-1:0] idx, next_idx, fill, next_fill, wa;
	logic busy, next_busy, we;
	logic [7:0] wd, rdat;

	// Index, fill walk and write port; only the queue is touched, limits live elsewhere
	always_comb begin
		next_idx = idx;
		next_fill = fill;
		next_busy = busy;
		we = 1'b0;
		wa = '0;
		wd = HIST_FILL;
		if (q.clear) begin
			next_idx = '0;
			next_fill = IW'(1);
			next_busy = 1'b1;
			we = 1'b1;
			wa = '0;
			wd = q.temp;
		end else if (busy) begin
			// One entry per cycle keeps it to a single write port
			next_fill = IW'(fill + 1'b1);
			next_busy = (fill != LAST);
			we = 1'b1;
			wa = fill;
			wd = HIST_FILL;
		end else if (q.sample) begin
			next_idx = (idx == LAST) ? '0 : IW'(idx + 1'b1);
			we = 1'b1;
			wa = next_idx;
			wd = q.temp;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx <= '0;
			fill <= '0;
			busy <= 1'b0;
		end else begin
			idx <= next_idx;
			fill <= next_fill;
			busy <= next_busy;
		end
	end

	// Array has no reset; contents are history, not control
	always_ff @(posedge clk) begin
		if (we) begin
			mem[wa] <= wd;
		end
		rdat <= mem[q.rd_idx];
	end

	assign q.busy = busy;
	assign q.idx = idx;
	assign q.rd_data = rdat;

	first_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
		q.clear |=> (mem[0] == $past(q.temp)) && (idx == '0) && busy)
		else $error("queue head not loaded on reset");
endmodule
`default_nettype wire

// [fcc_wcache.sv]
`timescale 1ns/1ps
`default_nettype none
module fcc_wcache
	import fcc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Controller side
	fcc_wc_if.cache w
);
	logic setf_bit, next_setf, on, next_on, done;

	// Set-features choice only counts while policy is automatic
	always_comb begin
		next_setf = setf_bit;
		if (w.setf_req && w.mode == WC_AUTO) begin
			next_setf = w.setf_en;
		end
		case (w.mode)
			WC_ON: next_on = 1'b1;
			WC_OFF: next_on = 1'b0;
			default: next_on = next_setf;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			setf_bit <= SETF_DEF;
			on <= SETF_DEF;
			done <= 1'b0;
		end else begin
			setf_bit <= next_setf;
			on <= next_on;
			done <= w.setf_req;
		end
	end

	assign w.wc_on = on;
	assign w.setf_done = done;

	forced_on_a: assert property (@(posedge clk) disable iff (!rst_n)
		(w.mode == WC_ON) |=> on)
		else $error("cache not forced on");
	forced_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		(w.mode == WC_OFF) |=> !on)
		else $error("cache not forced off");
	setf_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
		(w.setf_req && w.mode != WC_AUTO && $stable(w.mode)) |=> (on == $past(on)) && done)
		else $error("forced cache state changed by set-features");
endmodule
`default_nettype wire

// [fcc_feature_ctl.sv]
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fcc_feature_ctl
	import fcc_pkg::*;
#(
	parameter int HIST_DEPTH = 128
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Drive events
	input wire logic hard_reset,
	input wire logic setf_req,
	input wire logic setf_en,
	output logic setf_done,
	input wire logic minute_tick,
	input wire logic [7:0] cur_temp,
	// Feature levels
	output logic wc_active,
	output logic id85_wc,
	output logic reorder_on,
	output logic [15:0] log_interval
);
	localparam int IW = $clog2(HIST_DEPTH);

	fcc_q_if #(.IW(IW)) qif();
	fcc_wc_if wif();

	fcc_hist #(.DEPTH(HIST_DEPTH)) u_hist(.clk(clk), .rst_n(rst_n), .q(qif));
	fcc_wcache u_wc(.clk(clk), .rst_n(rst_n), .w(wif));

	fcc_state_e st, next_st;
	logic [15:0] func, feat, sval, opt, next_func, next_feat, next_sval, next_opt;
	logic [15:0] wc_st, ro_st, log_iv, next_wc, next_ro, next_log;
	logic [15:0] nv_wc, nv_ro, nv_log, next_nv_wc, next_nv_ro, next_nv_log;
	logic [2:0] pflag, next_pflag;
	logic [7:0] sc, sn, stat, err, next_sc, next_sn, next_stat, next_err;
	logic done, next_done, qclr, next_qclr, qsmp, next_qsmp;
	logic [15:0] mcnt, next_mcnt;
	logic [IW-1:0] hsel, next_hsel;
	logic [31:0] next_rdata;
	logic cmd_ok;
	logic [15:0] cur_state, cur_flags;

	// Valid state value for a feature on a set
	function automatic logic state_ok(input logic [15:0] f, input logic [15:0] s);
		case (f)
			FEAT_WC: state_ok = (s == WC_AUTO) || (s == WC_ON) || (s == WC_OFF);
			FEAT_RO: state_ok = (s == RO_EN) || (s == RO_DIS);
			FEAT_LOG: state_ok = (s != LOG_BAD);
			default: state_ok = 1'b0;
		endcase
	endfunction

	// Decode of the staged command
	always_comb begin
		cur_state = '0;
		cur_flags = '0;
		case (feat)
			FEAT_WC: begin
				cur_state = wc_st;
				cur_flags = {15'h0000, pflag[0]};
			end
			FEAT_RO: begin
				cur_state = ro_st;
				cur_flags = {15'h0000, pflag[1]};
			end
			FEAT_LOG: begin
				cur_state = log_iv;
				cur_flags = {15'h0000, pflag[2]};
			end
			default: begin
				cur_state = '0;
			end
		endcase
		// Reserved and vendor feature codes are not supported
		cmd_ok = (feat == FEAT_WC) || (feat == FEAT_RO) || (feat == FEAT_LOG);
		if (func == FUNC_SET) begin
			cmd_ok = cmd_ok && state_ok(feat, sval);
		end else if (func != FUNC_GET && func != FUNC_OPT) begin
			cmd_ok = 1'b0;
		end
	end

	// Sequencer, feature state and result registers
	always_comb begin
		next_st = st;
		next_func = func;
		next_feat = feat;
		next_sval = sval;
		next_opt = opt;
		next_wc = wc_st;
		next_ro = ro_st;
		next_log = log_iv;
		next_nv_wc = nv_wc;
		next_nv_ro = nv_ro;
		next_nv_log = nv_log;
		next_pflag = pflag;
		next_sc = sc;
		next_sn = sn;
		next_stat = stat;
		next_err = err;
		next_done = done;
		next_qclr = 1'b0;
		next_hsel = hsel;
		// Staging registers only change while idle so a running command sees stable inputs
		if (wr && st == S_IDLE) begin
			case (addr)
				A_FUNC: next_func = wdata[15:0];
				A_FEAT: next_feat = wdata[15:0];
				A_STATE: next_sval = wdata[15:0];
				A_OPT: next_opt = wdata[15:0];
				default: next_func = func;
			endcase
		end
		if (wr && addr == A_HSEL) begin
			next_hsel = wdata[IW-1:0];
		end
		case (st)
			S_IDLE: begin
				if (wr && addr == A_GO) begin
					next_done = 1'b0;
					if (wdata[15:0] == ACT_FEATURE) begin
						next_st = S_EXEC;
					end else begin
						next_done = 1'b1;
						next_stat = ST_ERR;
						next_err = ER_ABRT;
						next_sc = '0;
						next_sn = '0;
					end
				end
			end
			S_EXEC: begin
				next_st = S_IDLE;
				next_done = 1'b1;
				// Reserved outputs read as zero
				next_sc = '0;
				next_sn = '0;
				next_stat = cmd_ok ? ST_OK : ST_ERR;
				next_err = cmd_ok ? ER_OK : ER_ABRT;
				if (cmd_ok) begin
					case (func)
						FUNC_GET: begin
							next_sc = cur_state[7:0];
							next_sn = cur_state[15:8];
						end
						FUNC_OPT: begin
							next_sc = cur_flags[7:0];
							next_sn = cur_flags[15:8];
						end
						default: begin
							case (feat)
								FEAT_WC: begin
									next_wc = sval;
									next_pflag[0] = opt[OPT_NV_BIT];
									if (opt[OPT_NV_BIT]) next_nv_wc = sval;
								end
								FEAT_RO: begin
									// Disable is accepted and dropped
									next_pflag[1] = opt[OPT_NV_BIT];
									if (sval == RO_EN) begin
										next_ro = sval;
										if (opt[OPT_NV_BIT]) next_nv_ro = sval;
									end
								end
								default: begin
									next_log = sval;
									next_pflag[2] = opt[OPT_NV_BIT];
									if (opt[OPT_NV_BIT]) next_nv_log = sval;
									next_qclr = 1'b1;
									next_done = 1'b0;
									next_st = S_WAIT;
								end
							endcase
						end
					endcase
				end
			end
			S_WAIT: begin
				// Held until the fill is over; busy only rises the cycle after the clear pulse
				if (!qif.busy && !qclr) begin
					next_st = S_IDLE;
					next_done = 1'b1;
				end
			end
			default: next_st = S_IDLE;
		endcase
		// Hard reset falls back to the persistent copies
		if (hard_reset) begin
			next_wc = nv_wc;
			next_ro = nv_ro;
			next_log = nv_log;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= S_IDLE;
			func <= '0;
			feat <= '0;
			sval <= '0;
			opt <= '0;
			wc_st <= WC_AUTO;
			ro_st <= RO_EN;
			log_iv <= LOG_DEF;
			nv_wc <= WC_AUTO;
			nv_ro <= RO_EN;
			nv_log <= LOG_DEF;
			pflag <= '0;
			sc <= '0;
			sn <= '0;
			stat <= ST_OK;
			err <= ER_OK;
			done <= 1'b0;
			qclr <= 1'b0;
			hsel <= '0;
		end else begin
			st <= next_st;
			func <= next_func;
			feat <= next_feat;
			sval <= next_sval;
			opt <= next_opt;
			wc_st <= next_wc;
			ro_st <= next_ro;
			log_iv <= next_log;
			nv_wc <= next_nv_wc;
			nv_ro <= next_nv_ro;
			nv_log <= next_nv_log;
			pflag <= next_pflag;
			sc <= next_sc;
			sn <= next_sn;
			stat <= next_stat;
			err <= next_err;
			done <= next_done;
			qclr <= next_qclr;
			hsel <= next_hsel;
		end
	end

	// Minute counter paces history samples; restarts with each queue reset
	always_comb begin
		next_mcnt = mcnt;
		next_qsmp = 1'b0;
		if (qclr) begin
			next_mcnt = '0;
		end else if (minute_tick) begin
			if (16'(mcnt + 1'b1) >= log_iv) begin
				next_mcnt = '0;
				next_qsmp = 1'b1;
			end else begin
				next_mcnt = 16'(mcnt + 1'b1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mcnt <= '0;
			qsmp <= 1'b0;
		end else begin
			mcnt <= next_mcnt;
			qsmp <= next_qsmp;
		end
	end

	// Read mux; cylinder and device/head bytes stay zero in the upper half
	always_comb begin
		case (addr)
			A_FUNC: next_rdata = {16'h0000, func};
			A_FEAT: next_rdata = {16'h0000, feat};
			A_STATE: next_rdata = {16'h0000, sval};
			A_OPT: next_rdata = {16'h0000, opt};
			A_RES: next_rdata = {14'h0000, st != S_IDLE, done, err, stat};
			A_TF: next_rdata = {16'h0000, sn, sc};
			A_WC: next_rdata = {16'h0000, wc_st};
			A_RO: next_rdata = {16'h0000, ro_st};
			A_LOG: next_rdata = {16'h0000, log_iv};
			A_INFO: next_rdata = {31'h00000000, wif.wc_on};
			A_HSEL: next_rdata = {{(32 - IW){1'b0}}, hsel};
			A_HDATA: next_rdata = {24'h000000, qif.rd_data};
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= rd ? next_rdata : 32'h00000000;
		end
	end

	// Links to the submodules and pins
	assign qif.clear = qclr;
	assign qif.sample = qsmp;
	assign qif.temp = cur_temp;
	assign qif.rd_idx = hsel;
	assign wif.mode = wc_st;
	assign wif.setf_req = setf_req;
	assign wif.setf_en = setf_en;
	assign setf_done = wif.setf_done;
	assign wc_active = wif.wc_on;
	assign id85_wc = wif.wc_on;
	assign reorder_on = (ro_st == RO_EN);
	assign log_interval = log_iv;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	get_result_a: assert property ((st == S_EXEC && cmd_ok && func == FUNC_GET)
		|=> (sc == $past(cur_state[7:0])) && (sn == $past(cur_state[15:8])) && done)
		else $error("return-state bytes wrong");
	opt_result_a: assert property ((st == S_EXEC && cmd_ok && func == FUNC_OPT)
		|=> (sc == $past(cur_flags[7:0])) && (sn == $past(cur_flags[15:8])))
		else $error("option flag bytes wrong");
	set_reserved_a: assert property ((st == S_EXEC && func == FUNC_SET) |=> sc == '0 && sn == '0)
		else $error("reserved bytes not zero");
	zero_interval_a: assert property ((st == S_EXEC && feat == FEAT_LOG && func == FUNC_SET
		&& sval == LOG_BAD && !hard_reset) |=> (err == ER_ABRT) && $stable(log_iv))
		else $error("zero interval not aborted");
	reorder_drop_a: assert property ((st == S_EXEC && feat == FEAT_RO && func == FUNC_SET
		&& sval == RO_DIS && !hard_reset) |=> (err == ER_OK) && (ro_st == $past(ro_st)))
		else $error("reorder disable applied or errored");
	queue_reset_a: assert property ((st == S_EXEC && cmd_ok && feat == FEAT_LOG
		&& func == FUNC_SET) |=> qclr ##1 (qif.busy && st == S_WAIT && !done))
		else $error("interval set did not reset queue");
	hard_revert_a: assert property (hard_reset |=> (wc_st == $past(nv_wc))
		&& (log_iv == $past(nv_log)))
		else $error("hard reset did not revert");
	id_word_a: assert property ((wc_st == WC_OFF) [*2] |-> !id85_wc)
		else $error("identify bit disagrees with cache");
	abort_code_a: assert property ((st == S_EXEC && !cmd_ok) |=> stat == ST_ERR && err == ER_ABRT)
		else $error("bad command not aborted");

	set_log_c: cover property (st == S_WAIT ##1 st == S_IDLE);
	get_wc_c: cover property (st == S_EXEC && cmd_ok && func == FUNC_GET && feat == FEAT_WC);
	abort_c: cover property (st == S_EXEC && !cmd_ok);
	forced_setf_c: cover property (setf_req && wc_st == WC_OFF);
endmodule
`default_nettype wire

// [fcc_drive_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Drive-side partner: set-features requests, temperature and logging ticks
module fcc_drive_model (
	// Clock
	input wire logic clk,
	// Set-features link
	output logic setf_req,
	output logic setf_en,
	input wire logic setf_done,
	// Sensors
	output logic minute_tick,
	output logic [7:0] cur_temp
);
	int done_cnt = 0;

	// Idle levels; logging time stands still so history stays predictable
	initial begin
		setf_req = 1'b0;
		setf_en = 1'b1;
		minute_tick = 1'b0;
		cur_temp = 8'h2A;
	end

	// Count completions so the bench can see every request answered
	always @(posedge clk) begin
		if (setf_done === 1'b1) begin
			done_cnt <= done_cnt + 1;
		end
	end

	// One-cycle request with its enable beside it
	task automatic setf(input logic en);
		@(posedge clk);
		setf_req <= 1'b1;
		setf_en <= en;
		@(posedge clk);
		setf_req <= 1'b0;
		setf_en <= ~en; // Released: inverse, so a stale value cannot pass
	endtask

	// New temperature, then n minute ticks with a low cycle between them
	task automatic tick(input int n, input logic [7:0] t);
		@(posedge clk);
		cur_temp <= t;
		repeat (n) begin
			@(posedge clk);
			minute_tick <= 1'b1;
			@(posedge clk);
			minute_tick <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fcc_pkg::*;
	localparam int DEPTH = 8;
	localparam logic [31:0] R_OK = 32'h0001_0050;
	localparam logic [31:0] R_AB = 32'h0001_0451;
	localparam logic [31:0] NOCHK = 32'hFFFF_FFFF;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic hard_reset = 1'b0;
	logic [31:0] rdata;
	logic setf_req, setf_en, setf_done, minute_tick, wc_active, id85_wc, reorder_on;
	logic [7:0] cur_temp;
	logic [15:0] log_interval;
	logic [31:0] v;
	logic [15:0] wc_tab [4] = '{WC_OFF, WC_ON, WC_AUTO, WC_AUTO};
	logic en_tab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
	logic exp_tab [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;

	always #2.5 clk = ~clk;

	fcc_feature_ctl #(.HIST_DEPTH(DEPTH)) fcc_feature_ctl_inst (.clk(clk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .hard_reset(hard_reset), .setf_req(setf_req),
		.setf_en(setf_en), .setf_done(setf_done), .minute_tick(minute_tick), .cur_temp(cur_temp),
		.wc_active(wc_active), .id85_wc(id85_wc), .reorder_on(reorder_on), .log_interval(log_interval));

	fcc_drive_model fcc_drive_model_inst (.clk(clk), .setf_req(setf_req), .setf_en(setf_en),
		.setf_done(setf_done), .minute_tick(minute_tick), .cur_temp(cur_temp));

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count = bad_count + 1;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	// Whole command: parameters, start, bounded poll, result and task file
	task automatic cmd(input logic [15:0] act, f, ft, st, op, input logic [31:0] exp_res, exp_tf);
		int n;
		wr_reg(A_FUNC, {16'h0, f});
		wr_reg(A_FEAT, {16'h0, ft});
		wr_reg(A_STATE, {16'h0, st});
		wr_reg(A_OPT, {16'h0, op});
		wr_reg(A_GO, {16'h0, act});
		n = 0;
		v = 32'h0;
		while (v[16] !== 1'b1 && n < 50) begin
			rd_reg(A_RES, v);
			n++;
		end
		check("result", v, exp_res);
		rd_reg(A_TF, v);
		check("cylinder and head", {16'h0, v[31:16]}, 32'h0);
		if (exp_tf !== NOCHK) begin
			check("task file", v, exp_tf);
		end
	endtask

	task automatic pulse_hard_reset();
		@(posedge clk);
		hard_reset <= 1'b1;
		@(posedge clk);
		hard_reset <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check("wc_active", {31'h0, wc_active}, 32'h1);
		check("id85_wc", {31'h0, id85_wc}, 32'h1);
		check("reorder_on", {31'h0, reorder_on}, 32'h1);
		check("log_interval", {16'h0, log_interval}, {16'h0, LOG_DEF});
		cmd(ACT_FEATURE, FUNC_GET, FEAT_WC, 16'h0, 16'h0, R_OK, {16'h0, WC_AUTO});
		rd_reg(8'h40, v);
		check("unmapped", v, 32'h0);
		wr_reg(A_LOG, 32'h0000_0009);
		rd_reg(A_LOG, v);
		check("read-only interval", v, {16'h0, LOG_DEF});
		$display("test defaults done");

		// Forced states must shrug off set-features; auto follows it
		for (int i = 0; i < 4; i++) begin
			cmd(ACT_FEATURE, FUNC_SET, FEAT_WC, wc_tab[i], 16'h0, R_OK, NOCHK);
			fcc_drive_model_inst.setf(en_tab[i]);
			repeat (3) @(posedge clk);
			check("wc_active", {31'h0, wc_active}, {31'h0, exp_tab[i]});
			check("id85_wc", {31'h0, id85_wc}, {31'h0, exp_tab[i]});
			cmd(ACT_FEATURE, FUNC_GET, FEAT_WC, 16'h0, 16'h0, R_OK, {16'h0, wc_tab[i]});
		end
		check("setf answers", fcc_drive_model_inst.done_cnt, 32'd4);
		$display("test write cache done");

		// Persistent set, volatile set, then hard reset
		cmd(ACT_FEATURE, FUNC_SET, FEAT_WC, WC_ON, 16'h1, R_OK, NOCHK);
		cmd(ACT_FEATURE, FUNC_OPT, FEAT_WC, 16'h0, 16'h0, R_OK, 32'h1);
		cmd(ACT_FEATURE, FUNC_SET, FEAT_WC, WC_OFF, 16'h0, R_OK, NOCHK);
		cmd(ACT_FEATURE, FUNC_OPT, FEAT_WC, 16'h0, 16'h0, R_OK, 32'h0);
		pulse_hard_reset();
		cmd(ACT_FEATURE, FUNC_GET, FEAT_WC, 16'h0, 16'h0, R_OK, {16'h0, WC_ON});
		check("wc_active", {31'h0, wc_active}, 32'h1);
		$display("test persistence done");

		// Disable is accepted but not applied
		cmd(ACT_FEATURE, FUNC_SET, FEAT_RO, RO_DIS, 16'h0, R_OK, NOCHK);
		check("reorder_on", {31'h0, reorder_on}, 32'h1);
		cmd(ACT_FEATURE, FUNC_GET, FEAT_RO, 16'h0, 16'h0, R_OK, {16'h0, RO_EN});
		$display("test reordering done");

		// Zero interval refused, real interval clears the history
		cmd(ACT_FEATURE, FUNC_SET, FEAT_LOG, LOG_BAD, 16'h0, R_AB, 32'h0);
		check("log_interval", {16'h0, log_interval}, {16'h0, LOG_DEF});
		cmd(ACT_FEATURE, FUNC_SET, FEAT_LOG, 16'h0005, 16'h0, R_OK, NOCHK);
		check("log_interval", {16'h0, log_interval}, 32'h5);
		for (int i = 0; i < DEPTH; i++) begin
			wr_reg(A_HSEL, i);
			rd_reg(A_HDATA, v);
			check("history", v, (i == 0) ? {24'h0, cur_temp} : {24'h0, HIST_FILL});
		end
		// Interval 5: four ticks leave the next entry alone, the fifth appends a sample
		fcc_drive_model_inst.tick(4, 8'h33);
		repeat (3) @(posedge clk);
		wr_reg(A_HSEL, 32'h1);
		rd_reg(A_HDATA, v);
		check("history before interval", v, {24'h0, HIST_FILL});
		fcc_drive_model_inst.tick(1, 8'h33);
		repeat (3) @(posedge clk);
		wr_reg(A_HSEL, 32'h1);
		rd_reg(A_HDATA, v);
		check("history sample", v, 32'h0000_0033);
		cmd(ACT_FEATURE, FUNC_SET, FEAT_LOG, 16'hFFFF, 16'h0, R_OK, NOCHK);
		cmd(ACT_FEATURE, FUNC_GET, FEAT_LOG, 16'h0, 16'h0, R_OK, 32'hFFFF);
		$display("test logging done");

		// Reserved feature, unknown function, wrong action code
		cmd(ACT_FEATURE, FUNC_SET, 16'h0004, 16'h0001, 16'h0, R_AB, 32'h0);
		cmd(ACT_FEATURE, 16'h0004, FEAT_WC, 16'h0, 16'h0, R_AB, 32'h0);
		cmd(16'h0003, FUNC_GET, FEAT_WC, 16'h0, 16'h0, R_AB, 32'h0);
		$display("test refusals done");
		finish_test();
	end
endmodule
`default_nettype wire
